// ### src/mad_pkg.sv
// Operation
// R1: eight-bit level mask, reset 1001_1111
// R2: software writes zero to mask bits 6:5
// R3: nine-bit one-hot level result in bits 10:2
// R4: read-only valid flag in bit 1
// R5: presence bit 0 set below 30k ohm
// R6: detection itself enables the selected reference
// R7: switched-off bias powered only around each measurement
// R8: wait bias startup delay before measuring
// R9: software uses 16ms startup with slow ramp
// R10: software uses 0.25ms startup with fast ramp
// R11: software clears discharge when bias switched
// R12: masked levels never appear in result
// R13: masked level reports next lower enabled level
// R14: measurement lasts 100 to 500 microseconds
// R15: detect only when enabled and mic mode
// R16: programmable gap between successive measurements
// R17: debounce of 2 or 4 identical measurements
// R18: valid stays set while detection enabled
// R19: one level bit, updated together with presence
package mad_pkg;

  // register indices
  localparam logic [15:0] ADDR_MODE = 16'h0293;
  localparam logic [15:0] ADDR_CTRL = 16'h02a3;
  localparam logic [15:0] ADDR_MASK = 16'h02a4;
  localparam logic [15:0] ADDR_STAT = 16'h02a5;

  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h1102;
  localparam logic [7:0] MASK_RESET = 8'h9f;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic MODE_SRC_RESET = 1'h0;

  // field positions
  localparam int CTRL_START_LSB = 12;
  localparam int CTRL_RATE_LSB = 8;
  localparam int CTRL_REF_LSB = 4;
  localparam int CTRL_DBT_BIT = 1;
  localparam int CTRL_ENA_BIT = 0;
  localparam int MODE_SRC_BIT = 13;
  localparam int MODE_LSB = 0;
  localparam int STAT_LVL_LSB = 2;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_PRES_BIT = 0;

  // writable bits of the control and mask registers
  localparam logic [15:0] CTRL_WMASK = 16'hff33;
  localparam logic [7:0] MASK_WMASK = 8'h9f;

  // encodings
  localparam logic [1:0] MODE_MIC_A = 2'h0;
  localparam logic [1:0] MODE_MIC_B = 2'h3;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [2:0] LVL_HIGH = 3'h6;
  localparam logic [2:0] LVL_OPEN = 3'h7;
  localparam logic [3:0] DELAY_CODE_MAX = 4'hc;
  localparam logic [2:0] DB_SHORT = 3'h2;
  localparam logic [2:0] DB_LONG = 3'h4;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int DELAY_UNIT_US = 250;
  localparam int DELAY_UNIT_CYCLES = CLK_HZ / 1_000_000 * DELAY_UNIT_US;
  localparam int MEAS_MAX_US = 500;
  localparam int MEAS_MAX_CYCLES = CLK_HZ / 1_000_000 * MEAS_MAX_US;
  localparam int TICKS_W = 12;
  localparam int CYC_W = 16;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_GAP = 4'b0010,
    ST_BIAS = 4'b0100,
    ST_MEAS = 4'b1000
  } mad_state_t;

endpackage : mad_pkg

// ### src/mad_sync.sv
`timescale 1ns/1ps
module mad_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // async input and filtered output
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] dout_reg;
  logic [WIDTH-1:0] dout_next;

  // accept a change once stages two and three agree
  always_comb begin
    dout_next = (s2_reg == s3_reg) ? s3_reg : dout_reg;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;

endmodule : mad_sync

// ### src/mad_debounce.sv
`timescale 1ns/1ps
module mad_debounce
  import mad_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // control
  input wire logic clear,
  input wire logic long_sel,
  // mapped samples
  input wire logic sample_stb,
  input wire logic [2:0] sample_code,
  // settled result
  output logic [8:0] level_result,
  output logic present,
  output logic valid
);

  logic [2:0] last_reg, last_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [8:0] lvl_reg, lvl_next;
  logic pres_reg, pres_next;
  logic valid_reg, valid_next;

  always_comb begin
    last_next = last_reg;
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    pres_next = pres_reg;
    valid_next = valid_reg;
    if (clear) begin
      cnt_next = 3'h0;
      lvl_next = 9'h000;
      pres_next = 1'b0;
      valid_next = 1'b0;
    end else if (sample_stb) begin
      // R17 count identical measurements
      if (sample_code == last_reg && cnt_reg != 3'h0) begin
        cnt_next = (cnt_reg == DB_LONG) ? cnt_reg : cnt_reg + 3'h1;
      end else begin
        cnt_next = 3'h1;
        last_next = sample_code;
      end
      if (cnt_next >= (long_sel ? DB_LONG : DB_SHORT)) begin
        // R19 one-hot level with presence together
        lvl_next = 9'h000;
        if (sample_code >= LVL_HIGH) begin
          lvl_next[8] = 1'b1;
        end else begin
          lvl_next[sample_code] = 1'b1;
        end
        // R5 present below 30k
        pres_next = (sample_code != LVL_OPEN);
        // R18 valid held while enabled
        valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 3'h0;
      cnt_reg <= 3'h0;
      lvl_reg <= 9'h000;
      pres_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
      pres_reg <= pres_next;
      valid_reg <= valid_next;
    end
  end

  assign level_result = lvl_reg;
  assign present = pres_reg;
  assign valid = valid_reg;

endmodule : mad_debounce

// ### src/mad_top.sv
`timescale 1ns/1ps
module mad_top
  import mad_pkg::*;
#(
  parameter int UNIT_CYCLES = DELAY_UNIT_CYCLES,
  parameter int MEAS_TIMEOUT = MEAS_MAX_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  output logic [15:0] reg_rdata,
  // reference control
  input wire logic [2:0] bias_source_enable,
  output logic [3:0] ref_request,
  output logic detect_pin_select,
  // measurement front end
  output logic meas_req,
  input wire logic meas_done_async,
  input wire logic [2:0] meas_level_async
);

  localparam logic [CYC_W-1:0] UNIT_LAST = CYC_W'(UNIT_CYCLES - 1);
  localparam logic [CYC_W-1:0] MEAS_LAST = CYC_W'(MEAS_TIMEOUT - 1);

  // startup or gap code to 0.25ms ticks
  function automatic logic [TICKS_W-1:0] delay_ticks(input logic [3:0] code);
    logic [3:0] c;
    c = (code > DELAY_CODE_MAX) ? DELAY_CODE_MAX : code;
    if (c == 4'h0) begin
      delay_ticks = '0;
    end else begin
      delay_ticks = TICKS_W'(1) << (c - 4'h1);
    end
  endfunction : delay_ticks

  // masked level falls to next lower enabled one
  function automatic logic [2:0] map_level(input logic [2:0] raw, input logic [7:0] mask);
    logic [2:0] r;
    logic found;
    r = 3'h0;
    found = 1'b0;
    if (raw == LVL_OPEN) begin
      r = LVL_OPEN;
    end else begin
      for (int i = 6; i >= 1; i--) begin
        if (!found && 3'(i) <= raw && ((i == 6) ? mask[7] : mask[i-1])) begin
          r = 3'(i);
          found = 1'b1;
        end
      end
    end
    map_level = r;
  endfunction : map_level

  // register state
  logic [15:0] ctrl_reg, ctrl_next;
  logic [7:0] mask_reg, mask_next;
  logic [1:0] mode_reg, mode_next;
  logic src_reg, src_next;
  logic [15:0] rdata_reg, rdata_next;

  // sequencer state
  mad_state_t state_reg, state_next;
  logic [CYC_W-1:0] cyc_reg, cyc_next;
  logic [TICKS_W-1:0] wait_reg, wait_next;
  logic done_prev_reg, done_prev_next;
  logic stb_reg, stb_next;
  logic [2:0] code_reg, code_next;
  logic [3:0] refreq_reg, refreq_next;
  logic req_reg, req_next;

  // synchronised front end
  logic [3:0] fe_sync;
  logic done_s;
  logic [2:0] level_s;

  // settled result
  logic [8:0] level_result;
  logic present_flag;
  logic valid_flag;

  // decoded controls
  logic run;
  logic need_bias;
  logic [1:0] ref_sel;
  logic [TICKS_W-1:0] start_ticks;
  logic [TICKS_W-1:0] gap_ticks;

  mad_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din({meas_done_async, meas_level_async}),
    .dout(fe_sync)
  );

  assign done_s = fe_sync[3];
  assign level_s = fe_sync[2:0];

  mad_debounce u_debounce (
    .clock(clock),
    .arst_n(arst_n),
    .clear(!run),
    .long_sel(ctrl_reg[CTRL_DBT_BIT]),
    .sample_stb(stb_reg),
    .sample_code(code_reg),
    .level_result(level_result),
    .present(present_flag),
    .valid(valid_flag)
  );

  always_comb begin
    ref_sel = ctrl_reg[CTRL_REF_LSB +: 2];
    // R15 mic detection only in mic mode
    run = ctrl_reg[CTRL_ENA_BIT] && (mode_reg == MODE_MIC_A || mode_reg == MODE_MIC_B);
    need_bias = (ref_sel != REF_SUPPLY) && !bias_source_enable[ref_sel - 2'h1];
    start_ticks = delay_ticks(ctrl_reg[CTRL_START_LSB +: 4]);
    gap_ticks = delay_ticks(ctrl_reg[CTRL_RATE_LSB +: 4]);
  end

  // register writes and reads
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    mode_next = mode_reg;
    src_next = src_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: begin
          ctrl_next = reg_wdata & CTRL_WMASK;
        end
        // R1 level mask, R2 bits 6:5 kept zero
        ADDR_MASK: begin
          mask_next = reg_wdata[7:0] & MASK_WMASK;
        end
        ADDR_MODE: begin
          mode_next = reg_wdata[MODE_LSB +: 2];
          src_next = reg_wdata[MODE_SRC_BIT];
        end
        default: begin
        end
      endcase
    end
    rdata_next = 16'h0000;
    unique case (reg_addr)
      ADDR_CTRL: begin
        rdata_next = ctrl_reg;
      end
      ADDR_MASK: begin
        rdata_next = {8'h00, mask_reg};
      end
      ADDR_MODE: begin
        rdata_next[MODE_LSB +: 2] = mode_reg;
        rdata_next[MODE_SRC_BIT] = src_reg;
      end
      // R3 level, R4 valid, R5 presence
      ADDR_STAT: begin
        rdata_next[STAT_LVL_LSB +: 9] = level_result;
        rdata_next[STAT_VALID_BIT] = valid_flag;
        rdata_next[STAT_PRES_BIT] = present_flag;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
      mode_reg <= MODE_RESET;
      src_reg <= MODE_SRC_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      mode_reg <= mode_next;
      src_reg <= src_next;
      rdata_reg <= rdata_next;
    end
  end

  // measurement sequencer
  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    wait_next = wait_reg;
    done_prev_next = done_s;
    stb_next = 1'b0;
    code_next = code_reg;
    if (!run) begin
      state_next = ST_IDLE;
      cyc_next = '0;
      wait_next = '0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_GAP: begin
          // R16 gap counted in 0.25ms ticks
          if (state_reg == ST_GAP && wait_reg != '0) begin
            if (cyc_reg == UNIT_LAST) begin
              cyc_next = '0;
              wait_next = wait_reg - TICKS_W'(1);
            end else begin
              cyc_next = cyc_reg + CYC_W'(1);
            end
          end else if (need_bias && start_ticks != '0) begin
            // R8 startup delay before measuring
            state_next = ST_BIAS;
            cyc_next = '0;
            wait_next = start_ticks;
          end else begin
            state_next = ST_MEAS;
            cyc_next = '0;
          end
        end
        ST_BIAS: begin
          if (wait_reg == '0) begin
            state_next = ST_MEAS;
            cyc_next = '0;
          end else if (cyc_reg == UNIT_LAST) begin
            cyc_next = '0;
            wait_next = wait_reg - TICKS_W'(1);
          end else begin
            cyc_next = cyc_reg + CYC_W'(1);
          end
        end
        ST_MEAS: begin
          // R14 result or timeout after 500us
          if (done_s && !done_prev_reg) begin
            // R12 R13 report only enabled levels
            code_next = map_level(level_s, mask_reg);
            stb_next = 1'b1;
            state_next = ST_GAP;
            cyc_next = '0;
            wait_next = gap_ticks;
          end else if (cyc_reg == MEAS_LAST) begin
            state_next = ST_GAP;
            cyc_next = '0;
            wait_next = gap_ticks;
          end else begin
            cyc_next = cyc_reg + CYC_W'(1);
          end
        end
      endcase
    end
    // R6 R7 reference on only around a measurement
    refreq_next = 4'h0;
    if (state_next == ST_BIAS || state_next == ST_MEAS) begin
      refreq_next[ref_sel] = 1'b1;
    end
    req_next = (state_next == ST_MEAS);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cyc_reg <= '0;
      wait_reg <= '0;
      done_prev_reg <= 1'b0;
      stb_reg <= 1'b0;
      code_reg <= 3'h0;
      refreq_reg <= 4'h0;
      req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      wait_reg <= wait_next;
      done_prev_reg <= done_prev_next;
      stb_reg <= stb_next;
      code_reg <= code_next;
      refreq_reg <= refreq_next;
      req_reg <= req_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign ref_request = refreq_reg;
  assign meas_req = req_reg;
  assign detect_pin_select = src_reg;

endmodule : mad_top

// ### sim/mad_top_assertions.sv
`timescale 1ns/1ps
module mad_top_assertions
  import mad_pkg::*;
#(
  parameter int UNIT_CYCLES = 4,
  parameter int MEAS_TIMEOUT = 50
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [15:0] reg_rdata,
  // reference and front end
  input wire logic [2:0] bias_source_enable,
  input wire logic [3:0] ref_request,
  input wire logic detect_pin_select,
  input wire logic meas_req,
  input wire logic meas_done_async,
  input wire logic [2:0] meas_level_async
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [15:0] bias_cnt;
  logic [15:0] meas_cnt;
  logic [3:0] wr_age;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bias_cnt <= 16'h0;
      meas_cnt <= 16'h0;
      wr_age <= 4'h0;
    end else begin
      bias_cnt <= (ref_request == 4'h0) ? 16'h0 : (meas_req ? bias_cnt : bias_cnt + 16'h1);
      meas_cnt <= meas_req ? meas_cnt + 16'h1 : 16'h0;
      wr_age <= reg_wr ? 4'h0 : ((wr_age == 4'hf) ? wr_age : wr_age + 4'h1);
    end
  end
  sequence s_stat_read;
    $past(reg_addr) == ADDR_STAT;
  endsequence
  sequence s_stop_write;
    reg_wr && ((reg_addr == ADDR_CTRL && !reg_wdata[CTRL_ENA_BIT]) ||
      (reg_addr == ADDR_MODE && reg_wdata[1:0] inside {2'h1, 2'h2}));
  endsequence
  property p_ref_onehot; $onehot0(ref_request); endproperty
  a_ref_onehot: assert property (p_ref_onehot) else $error("reference request not one-hot");
  property p_meas_ref; meas_req |-> $onehot(ref_request); endproperty
  a_meas_ref: assert property (p_meas_ref) else $error("measuring without reference");
  property p_ref_drop; $fell(meas_req) |-> ref_request == 4'h0; endproperty
  a_ref_drop: assert property (p_ref_drop) else $error("reference kept after measurement");
  property p_bias_wait; $rose(meas_req) |-> bias_cnt == 16'h0 || bias_cnt >= UNIT_CYCLES - 1; endproperty
  a_bias_wait: assert property (p_bias_wait) else $error("startup delay cut short");
  property p_meas_len; meas_cnt <= MEAS_TIMEOUT + 8; endproperty
  a_meas_len: assert property (p_meas_len) else $error("measurement too long");
  property p_stat_bits; s_stat_read |-> reg_rdata[15:11] == 5'h0 && reg_rdata[9:8] == 2'h0; endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("unused status bits set");
  property p_stat_onehot; s_stat_read ##0 reg_rdata[1] |-> $onehot(reg_rdata[10:2]); endproperty
  a_stat_onehot: assert property (p_stat_onehot) else $error("level not one-hot");
  property p_valid_hold;
    s_stat_read ##0 $past(reg_addr, 2) == ADDR_STAT ##0 wr_age >= 4'h6 ##0 $past(reg_rdata[1]) |-> reg_rdata[1];
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");
  property p_stop; s_stop_write |-> ##[1:3] (!meas_req && ref_request == 4'h0); endproperty
  a_stop: assert property (p_stop) else $error("detection kept running");
endmodule : mad_top_assertions

// ### sim/mad_front_model.sv
`timescale 1ns/1ps
module mad_front_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // test control
  input wire logic mute,
  input wire logic [2:0] code,
  // front end link
  input wire logic meas_req,
  output logic done,
  output logic [2:0] level
);
  logic [5:0] cnt;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 6'h0;
      done <= 1'b0;
    end else if (!meas_req) begin
      cnt <= 6'h0;
      done <= 1'b0;
    end else if (cnt < 6'h14 - {2'h0, code, 1'h0}) begin
      cnt <= cnt + 6'h1;
    end else begin
      done <= !mute;
    end
  end
  // idle level is never the last code
  assign level = meas_req ? code : ~code;
endmodule : mad_front_model

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import mad_pkg::*;
;
  logic clock, arst_n, reg_wr, mute, detect_pin_select, meas_req, done, hi;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] bias_source_enable, code, level;
  logic [3:0] ref_request;
  int n_mismatch, cmp_count, nb;
  logic [31:0] tv [12] = '{32'h9f000007, 32'h9f01000b, 32'h9f020013, 32'h9f030023, 32'h9f040043,
    32'h9f050083, 32'h9f060403, 32'h9f070402, 32'h9b030013, 32'h00050007, 32'h10060083, 32'h9f060403};
  logic [15:0] dbx [3] = '{16'h0403, 16'h000b, 16'h0013};
  mad_top #(.UNIT_CYCLES(4), .MEAS_TIMEOUT(50)) DUT (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .bias_source_enable(bias_source_enable),
    .ref_request(ref_request), .detect_pin_select(detect_pin_select), .meas_req(meas_req),
    .meas_done_async(done), .meas_level_async(level));
  mad_front_model FE (.clock(clock), .arst_n(arst_n), .mute(mute), .code(code), .meas_req(meas_req),
    .done(done), .level(level));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task check(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task rdc(input string n, input logic [15:0] a, input logic [15:0] e);
    @(negedge clock);
    reg_addr = a;
    repeat (2) @(negedge clock);
    check(n, e, reg_rdata);
  endtask : rdc
  task meas_wait(input int n);
    repeat (n) @(negedge meas_req);
    repeat (4) @(negedge clock);
  endtask : meas_wait
  task set_code(input logic [2:0] c);
    @(negedge meas_req);
    @(negedge clock);
    code = c;
  endtask : set_code
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    #2_500_000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    reg_addr = 16'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    bias_source_enable = 3'h0;
    code = 3'h0;
    mute = 1'b0;
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    rdc("mask", ADDR_MASK, 16'h009f);
    rdc("ctrl", ADDR_CTRL, CTRL_RESET);
    wr(ADDR_STAT, 16'hffff);
    rdc("status", ADDR_STAT, 16'h0000);
    rdc("unmapped", 16'h0100, 16'h0000);
    wr(ADDR_MASK, 16'h00ff);
    rdc("mask unused", ADDR_MASK, 16'h009f);
    $display("test registers done");
    wr(ADDR_CTRL, 16'h0011);
    for (int i = 0; i < 12; i++) begin
      wr(ADDR_MASK, {8'h00, tv[i][31:24]});
      set_code(tv[i][18:16]);
      meas_wait(3);
      rdc("level", ADDR_STAT, tv[i][15:0]);
    end
    $display("test levels done");
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CTRL, 16'h0011 | {14'h0, j[0], 1'h0});
      set_code(3'(j + 1));
      meas_wait(j ? 3 : 1);
      rdc("debounce early", ADDR_STAT, dbx[j]);
      meas_wait(1);
      rdc("debounce", ADDR_STAT, dbx[j + 1]);
    end
    $display("test debounce done");
    mute = 1'b1;
    set_code(3'h3);
    repeat (200) @(negedge clock);
    rdc("no sample", ADDR_STAT, 16'h0013);
    mute = 1'b0;
    wr(ADDR_MODE, 16'h2001);
    hi = 1'b0;
    repeat (60) @(negedge clock) hi |= meas_req;
    check("other mode", 16'h0, {15'h0, hi});
    check("pin", 16'h1, {15'h0, detect_pin_select});
    wr(ADDR_MODE, 16'h0003);
    meas_wait(4);
    rdc("mode 3", ADDR_STAT, 16'h0023);
    wr(ADDR_CTRL, 16'h0000);
    rdc("off", ADDR_STAT, 16'h0000);
    $display("test mode done");
    for (int p = 0; p < 2; p++) begin
      bias_source_enable = p ? 3'h7 : 3'h0;
      for (int r = 0; r < 4; r++) begin
        wr(ADDR_CTRL, 16'h0000);
        // fast ramp, 0.25ms startup, no discharge
        wr(ADDR_CTRL, 16'h1101 | {10'h0, 2'(r), 4'h0});
        nb = 0;
        for (int k = 0; k < 100 && !meas_req; k++) begin
          if (ref_request != 4'h0) nb++;
          @(negedge clock);
        end
        check("ref", 16'h1 << r, {12'h0, ref_request});
        check("bias wait", (r != 0 && p == 0) ? 16'h1 : 16'h0, {15'h0, nb > 0});
        nb = 0;
        @(negedge meas_req);
        while (!meas_req) begin
          @(negedge clock);
          nb++;
        end
        check("gap", 16'h1, {15'h0, nb >= 4});
      end
    end
    wr(ADDR_CTRL, 16'h0000);
    $display("test reference done");
    give_verdict();
  end
endmodule : tb_top
bind mad_top mad_top_assertions #(.UNIT_CYCLES(UNIT_CYCLES), .MEAS_TIMEOUT(MEAS_TIMEOUT)) u_chk (
  .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .bias_source_enable(bias_source_enable), .ref_request(ref_request),
  .detect_pin_select(detect_pin_select), .meas_req(meas_req), .meas_done_async(meas_done_async),
  .meas_level_async(meas_level_async));
